// File: design/fpec_map.vh
`ifndef FPEC_MAP_VH
`define FPEC_MAP_VH
`define FPEC_OFS_MODE 12'h000
`define FPEC_OFS_STATUS 12'h004
`define FPEC_OFS_EBSEL 12'h008
`define FPEC_OFS_GATE 12'h00c
`define FPEC_OFS_PROG_ADDR 12'h010
`define FPEC_OFS_ERR_EVT 12'h014
`define FPEC_OFS_IRQ_STAT 12'h018
`define FPEC_OFS_IRQ_MASK 12'h01c
`define FPEC_MODE_RST 8'h00
`define FPEC_BIT_WE 6
`define FPEC_BIT_ESU 5
`define FPEC_BIT_PSU 4
`define FPEC_BIT_EV 3
`define FPEC_BIT_PV 2
`define FPEC_BIT_E 1
`define FPEC_BIT_P 0
`define FPEC_BIT_ERR 7
`define FPEC_BIT_GATE 7
`define FPEC_EB_W 5
`define FPEC_EB0_LO 15'h0000
`define FPEC_EB1_LO 15'h0400
`define FPEC_EB2_LO 15'h0800
`define FPEC_EB3_LO 15'h0c00
`define FPEC_EB4_LO 15'h1000
`define FPEC_EB4_HI 15'h7fff
`define FPEC_UNIT_MASK 8'h7f
`endif

// File: design/fpec_top.v
`include "fpec_map.vh"
module fpec_top (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire flash_err_in,
  output reg erase_setup_o,
  output reg program_setup_o,
  output reg erase_mode_o,
  output reg program_mode_o,
  output reg erase_verify_o,
  output reg program_verify_o,
  output reg [14:0] erase_lo_o,
  output reg [14:0] erase_hi_o,
  output reg [14:0] prog_base_o,
  output reg protect_o,
  output reg irq
);
  reg [7:0] flash_mode_control_r;
  reg [7:0] mode_nxt;
  reg [4:0] erase_block_select_r;
  reg [4:0] eb_nxt;
  reg control_access_enable_r;
  reg operation_error_flag_r;
  reg [14:0] prog_addr_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg err_s1_r;
  reg err_s2_r;
  wire acc;
  wire wr;
  wire gated;
  wire we;
  wire err_evt;
  wire prog_evt;
  reg [31:0] rd_nxt;
  reg [14:0] lo_nxt;
  reg [14:0] hi_nxt;
  reg [1:0] irq_clr;
  reg [1:0] irq_set;
  reg [1:0] irq_stat_nxt;
  wire [7:0] unit_mask;

  function gated_ofs;
    input [11:0] a;
    begin
      gated_ofs = (a == `FPEC_OFS_MODE) || (a == `FPEC_OFS_STATUS) ||
        (a == `FPEC_OFS_EBSEL) || (a == `FPEC_OFS_PROG_ADDR);
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = gated_ofs(a) || (a == `FPEC_OFS_GATE) ||
        (a == `FPEC_OFS_ERR_EVT) || (a == `FPEC_OFS_IRQ_STAT) ||
        (a == `FPEC_OFS_IRQ_MASK);
    end
  endfunction

  // two-cycle access phase: pready rises one edge after setup
  assign acc = psel && penable && !pready;
  // writes land on the completing edge, with pready high
  assign wr = psel && penable && pready && pwrite;
  assign unit_mask = `FPEC_UNIT_MASK;
  // blocked registers answer with pslverr, nothing written
  assign gated = !gated_ofs(paddr) || control_access_enable_r;
  assign we = flash_mode_control_r[`FPEC_BIT_WE];
  // external error pin is asynchronous to clk
  assign err_evt = (err_s2_r && we &&
    (flash_mode_control_r[`FPEC_BIT_E] ||
     flash_mode_control_r[`FPEC_BIT_P])) ||
    (wr && gated && paddr == `FPEC_OFS_ERR_EVT && pwdata[0]);
  assign prog_evt = wr && gated && paddr == `FPEC_OFS_PROG_ADDR;

  always @* begin
    mode_nxt = flash_mode_control_r;
    if (wr && gated && paddr == `FPEC_OFS_MODE) begin
      mode_nxt = {1'b0, pwdata[6:0]};
      if (!pwdata[`FPEC_BIT_WE])
        mode_nxt = 8'h00;
    end
    if (operation_error_flag_r)
      mode_nxt[5:0] = 6'h00;
    eb_nxt = erase_block_select_r;
    if (wr && gated && paddr == `FPEC_OFS_EBSEL)
      eb_nxt = pwdata[4:0];
    // more than one bit set collapses to none
    if ((eb_nxt & (eb_nxt - 5'h01)) != 5'h00)
      eb_nxt = 5'h00;
    if (!mode_nxt[`FPEC_BIT_WE])
      eb_nxt = 5'h00;
  end

  // one-hot select only; anything else gives an empty range
  always @* begin
    lo_nxt = 15'h0000;
    hi_nxt = 15'h0000;
    case (erase_block_select_r)
      5'h01: begin
        lo_nxt = `FPEC_EB0_LO;
        hi_nxt = `FPEC_EB1_LO - 15'h0001;
      end
      5'h02: begin
        lo_nxt = `FPEC_EB1_LO;
        hi_nxt = `FPEC_EB2_LO - 15'h0001;
      end
      5'h04: begin
        lo_nxt = `FPEC_EB2_LO;
        hi_nxt = `FPEC_EB3_LO - 15'h0001;
      end
      5'h08: begin
        lo_nxt = `FPEC_EB3_LO;
        hi_nxt = `FPEC_EB4_LO - 15'h0001;
      end
      5'h10: begin
        lo_nxt = `FPEC_EB4_LO;
        hi_nxt = `FPEC_EB4_HI;
      end
      default: begin
        lo_nxt = 15'h0000;
        hi_nxt = 15'h0000;
      end
    endcase
  end

  // blocked reads return zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `FPEC_OFS_MODE: rd_nxt = {24'h00_0000, flash_mode_control_r};
      `FPEC_OFS_STATUS: rd_nxt = {24'h00_0000, operation_error_flag_r,
        7'h00};
      `FPEC_OFS_EBSEL: rd_nxt = {27'h000_0000, erase_block_select_r};
      `FPEC_OFS_GATE: rd_nxt = {24'h00_0000, control_access_enable_r,
        7'h00};
      `FPEC_OFS_PROG_ADDR: rd_nxt = {17'h0_0000, prog_addr_r};
      `FPEC_OFS_IRQ_STAT: rd_nxt = {30'h0000_0000, irq_stat_r};
      `FPEC_OFS_IRQ_MASK: rd_nxt = {30'h0000_0000, irq_mask_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
    if (!gated)
      rd_nxt = 32'h0000_0000;
  end

  // two flops: the pin error is asynchronous to clk
  always @(posedge clk) begin
    if (!rst_n) begin
      err_s1_r <= 1'h0;
      err_s2_r <= 1'h0;
    end else begin
      err_s1_r <= flash_err_in;
      err_s2_r <= err_s1_r;
    end
  end

  // response one edge after the first access edge
  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc && (!mapped(paddr) || !gated);
      if (acc && !pwrite)
        prdata <= rd_nxt;
      else
        prdata <= 32'h0000_0000;
    end
  end

  // mode and select move together on a write
  always @(posedge clk) begin
    if (!rst_n) begin
      flash_mode_control_r <= `FPEC_MODE_RST;
      erase_block_select_r <= 5'h00;
    end else begin
      flash_mode_control_r <= mode_nxt;
      erase_block_select_r <= eb_nxt;
    end
  end

  // the gate register itself is never blocked
  always @(posedge clk) begin
    if (!rst_n) begin
      control_access_enable_r <= 1'h0;
    end else if (wr && paddr == `FPEC_OFS_GATE) begin
      control_access_enable_r <= pwdata[`FPEC_BIT_GATE];
    end
  end

  // low seven bits forced to zero, never rejected
  always @(posedge clk) begin
    if (!rst_n) begin
      prog_addr_r <= 15'h0000;
    end else if (prog_evt) begin
      prog_addr_r <= pwdata[14:0] & ~{8'h00, unit_mask[6:0]};
    end
  end

  // set wins over write-one-to-clear in the same cycle
  always @* begin
    irq_clr = 2'h0;
    if (wr && paddr == `FPEC_OFS_IRQ_STAT)
      irq_clr = pwdata[1:0];
    irq_set = {prog_evt && pwdata[6:0] != 7'h00, err_evt};
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr && paddr == `FPEC_OFS_IRQ_MASK)
        irq_mask_r <= pwdata[1:0];
    end
  end

  // sticky until reset: protection persists
  always @(posedge clk) begin
    if (!rst_n) begin
      operation_error_flag_r <= 1'h0;
      protect_o <= 1'h0;
    end else begin
      if (err_evt)
        operation_error_flag_r <= 1'h1;
      protect_o <= operation_error_flag_r || err_evt;
    end
  end

  // levels follow the mode bits on the same edge as the write
  always @(posedge clk) begin
    if (!rst_n) begin
      erase_setup_o <= 1'h0;
      program_setup_o <= 1'h0;
      erase_verify_o <= 1'h0;
      program_verify_o <= 1'h0;
    end else begin
      erase_setup_o <= mode_nxt[`FPEC_BIT_ESU];
      program_setup_o <= mode_nxt[`FPEC_BIT_PSU];
      erase_verify_o <= mode_nxt[`FPEC_BIT_EV];
      program_verify_o <= mode_nxt[`FPEC_BIT_PV];
    end
  end

  // setup may be set in the same write; order left to software
  always @(posedge clk) begin
    if (!rst_n) begin
      erase_mode_o <= 1'h0;
      program_mode_o <= 1'h0;
    end else begin
      erase_mode_o <= mode_nxt[`FPEC_BIT_E] && mode_nxt[`FPEC_BIT_WE] &&
        mode_nxt[`FPEC_BIT_ESU];
      program_mode_o <= mode_nxt[`FPEC_BIT_P] && mode_nxt[`FPEC_BIT_WE] &&
        mode_nxt[`FPEC_BIT_PSU];
    end
  end

  // range trails the select by one edge
  always @(posedge clk) begin
    if (!rst_n) begin
      erase_lo_o <= 15'h0000;
      erase_hi_o <= 15'h0000;
      prog_base_o <= 15'h0000;
    end else begin
      erase_lo_o <= lo_nxt;
      erase_hi_o <= hi_nxt;
      prog_base_o <= prog_addr_r;
    end
  end

  // level, one edge behind the status bits
  always @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// File: dv/fpec_top_assertions.sv
module fpec_top_chk (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire erase_setup_o,
  input wire program_setup_o,
  input wire erase_mode_o,
  input wire program_mode_o,
  input wire erase_verify_o,
  input wire program_verify_o,
  input wire [14:0] erase_lo_o,
  input wire [14:0] erase_hi_o,
  input wire [14:0] prog_base_o,
  input wire protect_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  emode_setup_a: assert property (erase_mode_o |-> erase_setup_o)
    else $error("erase mode without erase setup");
  pmode_setup_a: assert property (
    program_mode_o |-> program_setup_o)
    else $error("program mode without program setup");
  prot_sticky_a: assert property (protect_o |=> protect_o)
    else $error("protection dropped");
  prot_quiet_a: assert property (protect_o |-> ##2
    !(erase_mode_o || program_mode_o))
    else $error("mode active under protection");
  blk_range_a: assert property ((erase_hi_o != 15'h0000) |->
    (erase_hi_o - erase_lo_o == 15'h03ff) ||
    (erase_lo_o == 15'h1000 && erase_hi_o == 15'h7fff))
    else $error("bad erase range");
  prog_align_a: assert property (prog_base_o[6:0] == 7'h00)
    else $error("program base not aligned");
  ev_cause_a: assert property ($rose(erase_verify_o) |->
    $past(psel && pwrite && paddr == 12'h000 && pwdata[6] &&
    pwdata[3]))
    else $error("erase verify rose without write");
  pv_cause_a: assert property ($rose(program_verify_o) |->
    $past(psel && pwrite && paddr == 12'h000 && pwdata[6] &&
    pwdata[2]))
    else $error("program verify rose without write");
endmodule
bind fpec_top fpec_top_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .erase_setup_o(erase_setup_o), .program_setup_o(program_setup_o),
  .erase_mode_o(erase_mode_o), .program_mode_o(program_mode_o),
  .erase_verify_o(erase_verify_o), .program_verify_o(program_verify_o),
  .erase_lo_o(erase_lo_o), .erase_hi_o(erase_hi_o),
  .prog_base_o(prog_base_o), .protect_o(protect_o));

// File: dv/fpec_top_tb_top.sv
module fpec_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic flash_err_in = 0, pready, pslverr, er, irq, protect_o;
  logic erase_setup_o, program_setup_o, erase_mode_o, program_mode_o;
  logic erase_verify_o, program_verify_o;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [14:0] erase_lo_o, erase_hi_o, prog_base_o, lo;
  int bad_count = 0, comparisons = 0;
  fpec_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_err_in(flash_err_in),
    .erase_setup_o(erase_setup_o), .program_setup_o(program_setup_o),
    .erase_mode_o(erase_mode_o), .program_mode_o(program_mode_o),
    .erase_verify_o(erase_verify_o), .program_verify_o(program_verify_o),
    .erase_lo_o(erase_lo_o), .erase_hi_o(erase_hi_o),
    .prog_base_o(prog_base_o), .protect_o(protect_o), .irq(irq));
  initial forever #2.5 clk = ~clk;
  task end_sim;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // single transfer; one idle cycle between calls avoids double drive
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_sim;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task w2;
    repeat (2) @(posedge clk);
  endtask
  task t_gate;
    apb(0, 12'h000, 0); chk("gated", er, 1);
    apb(1, 12'h000, 8'h40); chk("gated_w", er, 1);
    apb(1, 12'h00c, 32'h0000_0080);
    apb(0, 12'h000, 0); chk("mode", rd, 0); chk("open", er, 0);
    apb(0, 12'h020, 0); chk("unmapped", er, 1);
    $display("gate test done");
  endtask
  task t_mode;
    apb(1, 12'h000, 8'h3f); apb(0, 12'h000, 0); chk("nowe", rd, 0);
    apb(1, 12'h000, 8'hc0); apb(0, 12'h000, 0); chk("b7", rd, 8'h40);
    apb(1, 12'h000, 8'h60); apb(1, 12'h000, 8'h62); w2;
    chk("esu", erase_setup_o, 1); chk("em", erase_mode_o, 1);
    apb(1, 12'h000, 8'h42); w2;
    chk("em_off", {erase_setup_o, erase_mode_o}, 0);
    apb(1, 12'h000, 8'h50); apb(1, 12'h000, 8'h51); w2;
    chk("pm", {program_setup_o, program_mode_o}, 3);
    apb(1, 12'h000, 8'h41); w2; chk("pm_off", program_mode_o, 0);
    apb(1, 12'h000, 8'h4c); w2;
    chk("ver", {erase_verify_o, program_verify_o}, 3);
    apb(1, 12'h000, 8'h40); w2;
    chk("ver_off", {erase_verify_o, program_verify_o}, 0);
    $display("mode test done");
  endtask
  task t_block;
    for (int i = 0; i < 5; i++) begin
      apb(1, 12'h008, 1 << i); w2;
      lo = (i < 4) ? 15'h0400 * i : 15'h1000;
      chk("lo", erase_lo_o, lo);
      chk("hi", erase_hi_o, (i < 4) ? lo + 15'h03ff : 15'h7fff);
    end
    apb(1, 12'h008, 8'h03); apb(0, 12'h008, 0); chk("multi", rd, 0);
    apb(1, 12'h008, 8'h01); apb(1, 12'h000, 0);
    apb(0, 12'h008, 0); chk("we_clr", rd, 0);
    $display("block test done");
  endtask
  task t_prog;
    apb(1, 12'h010, 16'h1080); w2;
    chk("base", prog_base_o, 16'h1080);
    apb(1, 12'h010, 16'h1081); w2; chk("noirq", irq, 0);
    chk("base2", prog_base_o, 16'h1080);
    apb(1, 12'h01c, 8'h02); w2; chk("irq", irq, 1);
    apb(1, 12'h018, 8'h02); w2; chk("irq_clr", irq, 0);
    $display("program test done");
  endtask
  task t_err;
    apb(1, 12'h000, 8'h40); apb(1, 12'h000, 8'h50); apb(1, 12'h000, 8'h51);
    @(posedge clk); flash_err_in <= 1;
    repeat (6) @(posedge clk); flash_err_in <= 0; w2;
    chk("prot", protect_o, 1); chk("pm_err", program_mode_o, 0);
    apb(0, 12'h004, 0); chk("flag", rd, 8'h80);
    apb(1, 12'h000, 8'h60); apb(0, 12'h000, 0);
    chk("frz", rd[5:0], 0);
    apb(1, 12'h018, 8'h01); apb(1, 12'h01c, 8'h01); w2;
    chk("irq_err_clr", irq, 0);
    apb(1, 12'h014, 8'h01); w2; chk("inject", irq, 1);
    $display("error test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_gate; t_mode; t_block; t_prog; t_err;
    end_sim;
  end
endmodule
